/* File: logic/buffer_level_watch.sv */
`timescale 1ns/1ns
module buffer_level_watch
   import evt_status_pkg::*;
#(
   parameter int CW = CNT_W
)(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          storeStb,
   input  wire logic          wrapStb,
   input  wire logic [CW-1:0] storeCount,
   input  wire logic [CW-1:0] bufSize,
   input  wire logic [CW-1:0] notifyCount,
   output logic               notifyHit,
   output logic               twoStored,
   output logic               quarterHit,
   output logic               halfHit,
   output logic               threeQuarterHit,
   output logic               fullHit,
   output logic               wrapHit
);
   logic [CW-1:0] quarterLvl;
   logic [CW-1:0] halfLvl;

   assign quarterLvl = bufSize >> 2;
   assign halfLvl    = bufSize >> 1;

   // ==========================================================
   // Level crossings, checked on each stored reading; wrap flag taken from each wrap strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         notifyHit       <= 1'b0;
         twoStored       <= 1'b0;
         quarterHit      <= 1'b0;
         halfHit         <= 1'b0;
         threeQuarterHit <= 1'b0;
         fullHit         <= 1'b0;
         wrapHit         <= 1'b0;
      end else begin
         notifyHit       <= storeStb && storeCount == notifyCount;
         twoStored       <= storeStb && storeCount >= CW'(MIN_TWO_STORED);
         quarterHit      <= storeStb && storeCount == quarterLvl;
         halfHit         <= storeStb && storeCount == halfLvl;
         threeQuarterHit <= storeStb && storeCount == CW'(halfLvl + quarterLvl);
         fullHit         <= storeStb && storeCount == bufSize;
         wrapHit         <= wrapStb;
      end
   end
endmodule

/* File: logic/event_flag_reg.sv */
`timescale 1ns/1ns
module event_flag_reg
   import evt_status_pkg::*;
#(
   parameter int                 W    = 16,
   parameter logic [WORD_W-1:0]  USED = 16'hFFFF
)(
   input  wire logic  clk,
   input  wire logic  sys_rst,
   evt_flag_if.owner  port
);
   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;
   logic [W-1:0] used;

   assign used = USED[W-1:0];

   // ==========================================================
   // Latch, clear on read or clear-status, set wins
   always_comb begin
      flags_d = flags_q;
      if (port.readClr || port.clearAll) begin
         flags_d = '0;
      end
      flags_d = flags_d | (port.setBits & used);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags_q <= FLAG_RESET[W-1:0];
      end else begin
         flags_q <= flags_d;
      end
   end

   assign port.flags = flags_q;
endmodule

/* File: logic/instrument_event_status_regs.sv */
`timescale 1ns/1ns
module instrument_event_status_regs
   import evt_status_pkg::*;
#(
   parameter int CW = CNT_W
)(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              queryStb,
   input  wire logic [SEL_W-1:0]  querySel,
   input  wire logic              enableWrStb,
   input  wire logic [SEL_W-1:0]  enableSel,
   input  wire logic [WORD_W-1:0] enableData,
   input  wire logic              clearStatus,
   input  wire logic              opsQuery,
   input  wire logic              allOpsDone,
   input  wire logic              respReadReq,
   input  wire logic              outQueueEmpty,
   input  wire logic              errStb,
   input  wire logic [ERR_W-1:0]  errCode,
   input  wire logic              cmdRunErr,
   input  wire logic              localKeyPress,
   input  wire logic              measuring,
   input  wire logic              waitTrigger,
   input  wire logic              filterSettled,
   input  wire logic              filterEnabled,
   input  wire logic              idleState,
   input  wire logic              readingDone,
   input  wire logic              overRange,
   input  wire logic [3:0]        limitHit,
   input  wire logic              hwLimitHit,
   input  wire logic              storeStb,
   input  wire logic              wrapStb,
   input  wire logic [CW-1:0]     storeCount,
   input  wire logic [CW-1:0]     bufSize,
   input  wire logic [CW-1:0]     notifyCount,
   output logic                   respValid,
   output logic [WORD_W-1:0]      respData,
   output logic                   stdSummary,
   output logic                   operSummary,
   output logic                   measSummary,
   output logic                   opsDoneResp
);
   evt_flag_if #(.W(STD_W))  stdIf ();
   evt_flag_if #(.W(WORD_W)) operIf ();
   evt_flag_if #(.W(WORD_W)) measIf ();

   logic [STD_W-1:0]  stdEn_q;
   logic [WORD_W-1:0] operEn_q;
   logic [WORD_W-1:0] measEn_q;
   logic              opsWait_q;
   logic              powerUp_q;
   logic              notifyHit;
   logic              twoStored;
   logic              quarterHit;
   logic              halfHit;
   logic              threeQuarterHit;
   logic              fullHit;
   logic              wrapHit;
   logic              opsFinish;
   logic              readStd;
   logic              readOper;
   logic              readMeas;

   function automatic logic isErr(input logic [ERR_W-1:0] code, input logic [ERR_W-1:0] ref1);
      return errStb && code == ref1;
   endfunction

   // ==========================================================
   // Flag registers
   event_flag_reg #(.W(STD_W), .USED({8'h00, STD_USED})) stdReg (
      .clk     (clk),
      .sys_rst (sys_rst),
      .port    (stdIf.owner)
   );
   event_flag_reg #(.W(WORD_W), .USED(OPER_USED)) operReg (
      .clk     (clk),
      .sys_rst (sys_rst),
      .port    (operIf.owner)
   );
   event_flag_reg #(.W(WORD_W), .USED(MEAS_USED)) measReg (
      .clk     (clk),
      .sys_rst (sys_rst),
      .port    (measIf.owner)
   );

   buffer_level_watch #(.CW(CW)) bufWatch (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .storeStb        (storeStb),
      .wrapStb         (wrapStb),
      .storeCount      (storeCount),
      .bufSize         (bufSize),
      .notifyCount     (notifyCount),
      .notifyHit       (notifyHit),
      .twoStored       (twoStored),
      .quarterHit      (quarterHit),
      .halfHit         (halfHit),
      .threeQuarterHit (threeQuarterHit),
      .fullHit         (fullHit),
      .wrapHit         (wrapHit)
   );

   // ==========================================================
   // Query decode and clears
   assign readStd  = queryStb && querySel == SEL_STD_EVT;
   assign readOper = queryStb && querySel == SEL_OPER_EVT;
   assign readMeas = queryStb && querySel == SEL_MEAS_EVT;

   assign stdIf.readClr   = readStd;
   assign operIf.readClr  = readOper;
   assign measIf.readClr  = readMeas;
   assign stdIf.clearAll  = clearStatus;
   assign operIf.clearAll = clearStatus;
   assign measIf.clearAll = clearStatus;

   // ==========================================================
   // Operation-done tracking
   assign opsFinish = opsWait_q && allOpsDone;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opsWait_q <= 1'b0;
      end else if (opsQuery) begin
         opsWait_q <= 1'b1;
      end else if (opsFinish) begin
         opsWait_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opsDoneResp <= 1'b0;
      end else begin
         opsDoneResp <= opsFinish;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         powerUp_q <= 1'b1;
      end else begin
         powerUp_q <= 1'b0;
      end
   end

   // ==========================================================
   // Standard event sources
   always_comb begin
      stdIf.setBits = '0;
      stdIf.setBits[B_OPS_DONE]     = opsFinish;
      stdIf.setBits[B_EMPTY_QUERY]  = respReadReq && outQueueEmpty;
      stdIf.setBits[B_BACKUP_RAM]   = isErr(errCode, ERR_NO_RESUME)
                                   || isErr(errCode, ERR_DATA_LOST);
      stdIf.setBits[B_CMD_RUN]      = cmdRunErr;
      stdIf.setBits[B_DEVICE_FAULT] = isErr(errCode, ERR_SETUP_MISM)
                                   || isErr(errCode, ERR_MODULE_LOST)
                                   || isErr(errCode, ERR_MODULE_UNSP);
      stdIf.setBits[B_FRONT_PANEL]  = localKeyPress;
      stdIf.setBits[B_POWER_CYCLED] = powerUp_q;
   end

   // ==========================================================
   // Operation event sources
   always_comb begin
      operIf.setBits = '0;
      operIf.setBits[B_CONVERTING] = measuring;
      operIf.setBits[B_WAIT_EVENT] = waitTrigger;
      operIf.setBits[B_SETTLED]    = filterSettled || !filterEnabled;
      operIf.setBits[B_IDLE]       = idleState;
   end

   // ==========================================================
   // Measurement event sources
   always_comb begin
      measIf.setBits = '0;
      measIf.setBits[B_RANGE_OVF]     = readingDone && overRange;
      measIf.setBits[B_LOW_ONE]       = readingDone && limitHit[0];
      measIf.setBits[B_UP_ONE]        = readingDone && limitHit[1];
      measIf.setBits[B_LOW_TWO]       = readingDone && limitHit[2];
      measIf.setBits[B_UP_TWO]        = readingDone && limitHit[3];
      measIf.setBits[B_NEW_READING]   = readingDone;
      measIf.setBits[B_COUNT_NOTIFY]  = notifyHit;
      measIf.setBits[B_TWO_STORED]    = twoStored;
      measIf.setBits[B_STORE_HALF]    = halfHit;
      measIf.setBits[B_STORE_FULL]    = fullHit;
      measIf.setBits[B_STORE_WRAP]    = wrapHit;
      measIf.setBits[B_HW_BOUND]      = readingDone && hwLimitHit;
      measIf.setBits[B_STORE_QUARTER] = quarterHit;
      measIf.setBits[B_STORE_3QUART]  = threeQuarterHit;
      measIf.setBits[B_ANY_LIMIT]     = readingDone && (|limitHit || hwLimitHit);
   end

   // ==========================================================
   // Enable registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stdEn_q  <= '0;
         operEn_q <= '0;
         measEn_q <= '0;
      end else if (enableWrStb) begin
         if (enableSel == SEL_STD_EN) begin
            stdEn_q <= enableData[STD_W-1:0];
         end
         if (enableSel == SEL_OPER_EN) begin
            operEn_q <= enableData;
         end
         if (enableSel == SEL_MEAS_EN) begin
            measEn_q <= enableData;
         end
      end
   end

   // ==========================================================
   // Summaries
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stdSummary  <= 1'b0;
         operSummary <= 1'b0;
         measSummary <= 1'b0;
      end else begin
         stdSummary  <= |(stdIf.flags & stdEn_q);
         operSummary <= |(operIf.flags & operEn_q);
         measSummary <= |(measIf.flags & measEn_q);
      end
   end

   // ==========================================================
   // Query response
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         respValid <= 1'b0;
         respData  <= '0;
      end else begin
         respValid <= queryStb;
         if (queryStb) begin
            unique case (querySel)
               SEL_STD_EVT:  respData <= {8'h00, stdIf.flags};
               SEL_OPER_EVT: respData <= operIf.flags;
               SEL_MEAS_EVT: respData <= measIf.flags;
               SEL_STD_EN:   respData <= {8'h00, stdEn_q};
               SEL_OPER_EN:  respData <= operEn_q;
               SEL_MEAS_EN:  respData <= measEn_q;
               default:      respData <= '0;
            endcase
         end
      end
   end

   // ==========================================================
   // Checks
   sequence readStdSeq;
      queryStb && querySel == SEL_STD_EVT;
   endsequence

   sequence quietStd;
      !readStd && !clearStatus;
   endsequence

   AST_OPS_DONE: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(stdIf.flags[B_OPS_DONE]) |-> $past(opsWait_q) && $past(allOpsDone))
      else $error("operation-done set without finished query");
   AST_EMPTY_READ: assert property (@(posedge clk) disable iff (sys_rst)
      respReadReq && outQueueEmpty |=> stdIf.flags[B_EMPTY_QUERY])
      else $error("empty read not flagged");
   AST_POWER_UP: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |=> stdIf.flags[B_POWER_CYCLED])
      else $error("power cycle flag missing");
   AST_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
      quietStd |=> (stdIf.flags & $past(stdIf.flags)) == $past(stdIf.flags))
      else $error("standard flag dropped without clear");
   AST_READ_BACK: assert property (@(posedge clk) disable iff (sys_rst)
      readStdSeq |=> respValid && respData == {8'h00, $past(stdIf.flags)}
      && stdIf.flags == $past(stdIf.setBits))
      else $error("standard read not returned and cleared");
   AST_SUMMARY: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 measSummary == |($past(measIf.flags) & $past(measEn_q)))
      else $error("measurement summary wrong");
   AST_UNUSED: assert property (@(posedge clk) disable iff (sys_rst)
      (operIf.flags & ~OPER_USED) == 16'h0000 && !stdIf.flags[1] && !measIf.flags[15])
      else $error("unused bit set");
   AST_FILTER: assert property (@(posedge clk) disable iff (sys_rst)
      !filterEnabled && !readOper && !clearStatus |=> operIf.flags[B_SETTLED])
      else $error("disabled filter not flagged settled");
   AST_ANY_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
      measIf.setBits[B_LOW_ONE] |=> measIf.flags[B_ANY_LIMIT] && measIf.flags[B_LOW_ONE])
      else $error("limit summary missing");
   AST_HALF: assert property (@(posedge clk) disable iff (sys_rst)
      storeStb && storeCount == (bufSize >> 1) |=> ##1 measIf.flags[B_STORE_HALF])
      else $error("half full not flagged");
endmodule

/* File: shared/evt_flag_if.sv */
`timescale 1ns/1ns
interface evt_flag_if #(parameter int W = 16);
   logic [W-1:0] setBits;
   logic         readClr;
   logic         clearAll;
   logic [W-1:0] flags;
   modport owner (input setBits, input readClr, input clearAll, output flags);
   modport user  (output setBits, output readClr, output clearAll, input flags);
endinterface

/* File: shared/evt_status_pkg.sv */
package evt_status_pkg;
   // ==========================================================
   // Register widths and query selects
   localparam int STD_W  = 8;
   localparam int WORD_W = 16;
   localparam int SEL_W  = 3;
   localparam int ERR_W  = 10;
   localparam int CNT_W  = 16;
   localparam logic [SEL_W-1:0] SEL_STD_EVT  = 3'h0;
   localparam logic [SEL_W-1:0] SEL_OPER_EVT = 3'h1;
   localparam logic [SEL_W-1:0] SEL_MEAS_EVT = 3'h2;
   localparam logic [SEL_W-1:0] SEL_STD_EN   = 3'h3;
   localparam logic [SEL_W-1:0] SEL_OPER_EN  = 3'h4;
   localparam logic [SEL_W-1:0] SEL_MEAS_EN  = 3'h5;
   // ==========================================================
   // Standard event bit positions
   localparam int B_OPS_DONE      = 0;
   localparam int B_EMPTY_QUERY   = 2;
   localparam int B_BACKUP_RAM    = 3;
   localparam int B_CMD_RUN       = 4;
   localparam int B_DEVICE_FAULT  = 5;
   localparam int B_FRONT_PANEL   = 6;
   localparam int B_POWER_CYCLED  = 7;
   // ==========================================================
   // Operation event bit positions
   localparam int B_CONVERTING    = 4;
   localparam int B_WAIT_EVENT    = 5;
   localparam int B_SETTLED       = 8;
   localparam int B_IDLE          = 10;
   // ==========================================================
   // Measurement event bit positions
   localparam int B_RANGE_OVF     = 0;
   localparam int B_LOW_ONE       = 1;
   localparam int B_UP_ONE        = 2;
   localparam int B_LOW_TWO       = 3;
   localparam int B_UP_TWO        = 4;
   localparam int B_NEW_READING   = 5;
   localparam int B_COUNT_NOTIFY  = 6;
   localparam int B_TWO_STORED    = 7;
   localparam int B_STORE_HALF    = 8;
   localparam int B_STORE_FULL    = 9;
   localparam int B_STORE_WRAP    = 10;
   localparam int B_HW_BOUND      = 11;
   localparam int B_STORE_QUARTER = 12;
   localparam int B_STORE_3QUART  = 13;
   localparam int B_ANY_LIMIT     = 14;
   // ==========================================================
   // Used-bit masks and reset values
   localparam logic [STD_W-1:0]  STD_USED   = 8'hFD;
   localparam logic [WORD_W-1:0] OPER_USED  = 16'h0530;
   localparam logic [WORD_W-1:0] MEAS_USED  = 16'h7FFF;
   localparam logic [WORD_W-1:0] FLAG_RESET = 16'h0000;
   // ==========================================================
   // Error codes routed to the standard event register, and the two-stored count threshold
   localparam logic [ERR_W-1:0] ERR_DATA_LOST   = 10'h204;
   localparam logic [ERR_W-1:0] ERR_NO_RESUME   = 10'h205;
   localparam logic [ERR_W-1:0] ERR_SETUP_MISM  = 10'h208;
   localparam logic [ERR_W-1:0] ERR_MODULE_LOST = 10'h20B;
   localparam logic [ERR_W-1:0] ERR_MODULE_UNSP = 10'h20C;
   localparam logic [CNT_W-1:0] MIN_TWO_STORED  = 16'h0002;
endpackage

/* File: sim/host_query_model.sv */
`timescale 1ns/1ns
module host_query_model
   import evt_status_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              reqGo,
   input  wire logic [SEL_W-1:0]  reqSel,
   input  wire logic              respValid,
   input  wire logic [WORD_W-1:0] respData,
   output logic                   queryStb,
   output logic [SEL_W-1:0]       querySel,
   output logic                   done,
   output logic [WORD_W-1:0]      gotData
);
   logic busy = 1'b0;
   initial begin
      queryStb = 1'b0;
      querySel = '0;
      done = 1'b0;
      gotData = '0;
   end
   // ==========================================
   // One query in flight, answer taken at its edge
   always @(posedge clk) begin
      queryStb <= 1'b0;
      done <= 1'b0;
      if (sys_rst) begin
         busy <= 1'b0;
      end else if (reqGo && !busy) begin
         queryStb <= 1'b1;
         querySel <= reqSel;
         busy <= 1'b1;
      end else if (respValid && busy) begin
         gotData <= respData;
         done <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule

/* File: sim/instrument_event_status_regs_bench.sv */
`timescale 1ns/1ns
module instrument_event_status_regs_bench;
   import evt_status_pkg::*;
   logic              clk = 1'b0;
   logic              sysRst = 1'b1;
   logic [9:0]        stb = '0;
   logic [4:0]        lvl = 5'h08;
   logic [5:0]        rd = '0;
   logic              allOpsDone = 1'b0;
   logic              outQueueEmpty = 1'b1;
   logic [ERR_W-1:0]  errCode = '0;
   logic [SEL_W-1:0]  enableSel = '0;
   logic [WORD_W-1:0] enableData = '0;
   logic [CNT_W-1:0]  storeCount = '0;
   logic [CNT_W-1:0]  bufSize = 16'h0008;
   logic [CNT_W-1:0]  notifyCount = '0;
   logic              reqGo = 1'b0;
   logic [SEL_W-1:0]  reqSel = '0;
   logic              queryStb, respValid, done, opsDoneResp;
   logic              stdSummary, operSummary, measSummary;
   logic [SEL_W-1:0]  querySel;
   logic [WORD_W-1:0] respData, gotData;
   logic [ERR_W-1:0]  codes [5] = '{10'h204, 10'h205, 10'h208, 10'h20B, 10'h20C};
   int                mismatches = 0;
   int                comparisons = 0;
   int                cycles = 0;
   int                i, c, n;
   integer            seed = 32'h2f92;
   logic [31:0]       v;

   instrument_event_status_regs instrument_event_status_regs_i (
      .clk(clk), .sys_rst(sysRst), .queryStb(queryStb), .querySel(querySel),
      .enableWrStb(stb[9]), .enableSel(enableSel), .enableData(enableData),
      .clearStatus(stb[8]), .opsQuery(stb[4]), .allOpsDone(allOpsDone),
      .respReadReq(stb[3]), .outQueueEmpty(outQueueEmpty), .errStb(stb[0]),
      .errCode(errCode), .cmdRunErr(stb[1]), .localKeyPress(stb[2]),
      .measuring(lvl[0]), .waitTrigger(lvl[1]), .filterSettled(lvl[2]),
      .filterEnabled(lvl[3]), .idleState(lvl[4]), .readingDone(stb[5]),
      .overRange(rd[0]), .limitHit(rd[4:1]), .hwLimitHit(rd[5]), .storeStb(stb[6]),
      .wrapStb(stb[7]), .storeCount(storeCount), .bufSize(bufSize),
      .notifyCount(notifyCount), .respValid(respValid), .respData(respData),
      .stdSummary(stdSummary), .operSummary(operSummary),
      .measSummary(measSummary), .opsDoneResp(opsDoneResp));

   host_query_model host_query_model_i (
      .clk(clk), .sys_rst(sysRst), .reqGo(reqGo), .reqSel(reqSel),
      .respValid(respValid), .respData(respData), .queryStb(queryStb),
      .querySel(querySel), .done(done), .gotData(gotData));

   // ==========================================
   // Clock, timeout, reporting
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task final_report;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task query(input logic [SEL_W-1:0] sel, input logic [15:0] exp);
      int k;
      @(posedge clk) reqGo <= 1'b1;
      reqSel <= sel;
      @(posedge clk) reqGo <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      if (done !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: no answer to query", $time);
      end
      check(gotData, exp);
   endtask
   task pulse(input int b);
      @(posedge clk) stb[b] <= 1'b1;
      @(posedge clk) stb[b] <= 1'b0;
   endtask
   // ==========================================
   // Expected flag words
   function automatic logic [15:0] expOper(input logic [4:0] x);
      return {5'h0, x[4], 1'b0, x[2] | ~x[3], 2'h0, x[1], x[0], 4'h0};
   endfunction
   function automatic logic [15:0] expMeas(input logic [5:0] x);
      return {1'b0, |x[5:1], 2'h0, x[5], 6'h01, x[4:0]};
   endfunction
   function automatic logic [15:0] expBuf(input int k, input int s, input int t);
      return {2'h0, k == s / 2 + s / 4, k == s / 4, 2'h0, k == s, k == s / 2,
              k >= 2, k == t, 6'h00};
   endfunction

   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      sysRst <= 1'b0;
      repeat (2) @(posedge clk);
      query(SEL_STD_EVT, 16'h0080);
      query(SEL_STD_EVT, 16'h0000);
      query(3'h6, 16'h0000);
      for (i = 0; i < 5; i++) begin
         @(posedge clk) errCode <= codes[i];
         pulse(0);
         query(SEL_STD_EVT, (i < 2) ? 16'h0008 : 16'h0020);
      end
      pulse(3);
      query(SEL_STD_EVT, 16'h0004);
      @(posedge clk) outQueueEmpty <= 1'b0;
      pulse(3);
      query(SEL_STD_EVT, 16'h0000);
      pulse(1);
      pulse(2);
      repeat (8) @(posedge clk);
      query(SEL_STD_EVT, 16'h0050);
      pulse(2);
      pulse(8);
      query(SEL_STD_EVT, 16'h0000);
      pulse(4);
      repeat (3) @(posedge clk);
      query(SEL_STD_EVT, 16'h0000);
      @(posedge clk) allOpsDone <= 1'b1;
      n = 0;
      repeat (4) begin
         @(posedge clk);
         if (opsDoneResp === 1'b1) n++;
      end
      check(16'(n), 16'h0001);
      allOpsDone <= 1'b0;
      query(SEL_STD_EVT, 16'h0001);
      for (i = 0; i < 10; i++) begin
         v = $random(seed);
         if (i == 0) v = 32'h0000_0008;
         @(posedge clk) lvl <= v[4:0];
         @(posedge clk) lvl <= 5'h08;
         query(SEL_OPER_EVT, expOper(v[4:0]));
      end
      for (i = 0; i < 10; i++) begin
         v = $random(seed);
         @(posedge clk) rd <= v[5:0];
         pulse(5);
         query(SEL_MEAS_EVT, expMeas(v[5:0]));
      end
      @(posedge clk) enableSel <= SEL_MEAS_EN;
      enableData <= 16'h0020;
      rd <= '0;
      pulse(9);
      query(SEL_MEAS_EN, 16'h0020);
      pulse(5);
      repeat (3) @(posedge clk);
      check(16'(measSummary), 16'h0001);
      query(SEL_MEAS_EVT, 16'h0020);
      repeat (3) @(posedge clk);
      check(16'(measSummary), 16'h0000);
      @(posedge clk) enableSel <= SEL_STD_EN;
      enableData <= 16'h0010;
      pulse(9);
      @(posedge clk) enableSel <= SEL_OPER_EN;
      enableData <= 16'h0400;
      pulse(9);
      query(SEL_STD_EN, 16'h0010);
      query(SEL_OPER_EN, 16'h0400);
      pulse(1);
      @(posedge clk) lvl <= 5'h18;
      @(posedge clk) lvl <= 5'h08;
      repeat (3) @(posedge clk);
      check(16'({stdSummary, operSummary}), 16'h0003);
      query(SEL_STD_EVT, 16'h0010);
      query(SEL_OPER_EVT, 16'h0400);
      repeat (3) @(posedge clk);
      check(16'({stdSummary, operSummary}), 16'h0000);
      for (n = 8; n <= 12; n += 4) begin
         v = ($random(seed) & 32'h0000_0007) + 1;
         @(posedge clk) bufSize <= 16'(n);
         notifyCount <= v[15:0];
         for (c = 1; c <= n; c++) begin
            @(posedge clk) storeCount <= 16'(c);
            pulse(6);
            query(SEL_MEAS_EVT, expBuf(c, n, v));
         end
      end
      pulse(7);
      query(SEL_MEAS_EVT, 16'h0400);
      final_report();
   end
endmodule
